// file: core/rpu_pkg.sv
// shared constants and types of the region protection unit
package rpu_pkg;
  // ==========================================================
  // register map (byte addresses)
  localparam int ADDR_W = 8;
  localparam logic [7:0] OFF_SYS_CTL = 8'h00;
  localparam logic [7:0] OFF_REGION_SEL = 8'h04;
  localparam logic [7:0] OFF_REGION_BASE = 8'h08;
  localparam logic [7:0] OFF_REGION_SIZE = 8'h0C;
  localparam logic [7:0] OFF_REGION_ACC = 8'h10;
  localparam logic [7:0] OFF_TCM_FIRST = 8'h14;
  localparam logic [7:0] OFF_TCM_SECOND0 = 8'h18;
  localparam logic [7:0] OFF_TCM_SECOND1 = 8'h1C;
  localparam logic [7:0] OFF_PERIPH = 8'h20;
  localparam logic [7:0] OFF_STATUS = 8'h24;
  // ==========================================================
  // field positions and reset values
  localparam int SC_ENABLE_BIT = 0;
  localparam int SC_ALIGN_BIT = 1;
  localparam int SC_BG_BIT = 17;
  localparam logic [31:0] SYS_CTL_RESET = 32'h0000_0000;
  localparam int SZ_EN_BIT = 0;
  localparam int SZ_SIZE_LO = 1;
  localparam int SZ_SUB_LO = 8;
  localparam int ACC_B_BIT = 0;
  localparam int ACC_C_BIT = 1;
  localparam int ACC_S_BIT = 2;
  localparam int ACC_TEX_LO = 3;
  localparam int ACC_AP_LO = 8;
  localparam int ACC_XN_BIT = 12;
  localparam int WIN_EN_BIT = 0;
  localparam logic [15:0] DEFAULT_ACC_MEM = 16'h030B;
  localparam logic [15:0] DEFAULT_ACC_DEV = 16'h1310;
  localparam int ST_BG_BIT = 0;
  localparam int ST_PERM_BIT = 1;
  localparam int ST_ALIGN_BIT = 2;
  localparam int ST_TCM_FIRST_ERR_BIT = 3;
  localparam int ST_TCM_SECOND_ERR_BIT = 4;
  // ==========================================================
  // memory types, cache policies and bus cache codes
  localparam logic [1:0] MT_STRONG = 2'h0;
  localparam logic [1:0] MT_DEVICE = 2'h1;
  localparam logic [1:0] MT_NORMAL = 2'h2;
  localparam logic [1:0] POL_NC = 2'h0;
  localparam logic [1:0] POL_WBWA = 2'h1;
  localparam logic [1:0] POL_WT = 2'h2;
  localparam logic [1:0] POL_WBNA = 2'h3;
  localparam logic [3:0] CODE_STRONG = 4'h0;
  localparam logic [3:0] CODE_DEVICE = 4'h1;
  localparam logic [3:0] CODE_NC = 4'h3;
  localparam logic [3:0] CODE_WT = 4'h6;
  localparam logic [3:0] CODE_WBNA = 4'h7;
  localparam logic [3:0] CODE_WBWA = 4'hF;
  // ==========================================================
  // enumerations
  typedef enum logic [3:0] {
    FAULT_NONE = 4'b0001,
    FAULT_BACKGROUND = 4'b0010,
    FAULT_PERMISSION = 4'b0100,
    FAULT_ALIGNMENT = 4'b1000
  } rpu_fault_type;
  typedef enum logic [5:0] {
    ROUTE_NONE = 6'b000001,
    ROUTE_TCM_FIRST = 6'b000010,
    ROUTE_TCM_SECOND = 6'b000100,
    ROUTE_CACHE = 6'b001000,
    ROUTE_MASTER = 6'b010000,
    ROUTE_PERIPH = 6'b100000
  } rpu_route_type;
  typedef struct packed {
    rpu_fault_type fault;
    rpu_route_type route;
    logic bank;
    logic [3:0] inner;
    logic [3:0] outer;
  } rpu_result_type;
endpackage

// file: core/rpu_core.sv
// region protection unit: region lookup, faults, L1 routing and bus attributes
//
// Implementation choices: the address map and the address-and-strobe port.
`timescale 1ns/1ps

// Notes on behaviour
// - memory type and policy come from type_extension_field plus C and B bits
// - every cacheable region is read-allocate
// - inner write-back no-allocate behaves as write-back write-allocate
// - shareable bit counts only for Normal memory, one shared, zero not
// - master port shows inner and outer attributes of the region
// - peripheral port shows the region's outer attributes, with Normal memory forced to non-cacheable
// - control bit 0 enables checking; cleared means default memory map
// - any fault aborts the access and nothing goes to master or peripheral
// - enabled unit faults accesses outside every enabled subregion
// - background option suppresses that fault for privileged accesses
// - read, write, privilege or execute violations raise a permission fault
// - misaligned data access faults when strict alignment applies
// - control alignment bit forces strict alignment on all data accesses
// - without the unit, region registers read zero and ignore writes
// - addresses in an enabled TCM window go to that TCM
// - other non-shared cacheable non-peripheral accesses look up the side's L1 cache
// - the rest go to L2 over the master or peripheral port
// - instructions only from instruction cache, data only from data cache
// - one TCM on the first port, two on the second, both sides
// - each TCM port takes an external error indication
// - both sides are checked for protection, permissions and attributes
// - overlapping regions: highest numbered region wins
// - control bit 17 gives privileged misses the default memory map
// - TCM addresses keep region memory type and permissions; a fetch there needs Normal memory
// - peripheral addresses are non-cacheable and no-execute
module rpu_core #(
  parameter int REGION_COUNT = 16,
  parameter bit REGION_PRESENT = 1'b1,
  parameter int TCM_SIZE_LOG2 = 16,
  parameter int PERIPH_SIZE_LOG2 = 20
) (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic ce,
  input wire logic [rpu_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  input wire logic i_valid,
  input wire logic [31:0] i_addr,
  input wire logic i_priv,
  output logic i_abort,
  output rpu_pkg::rpu_fault_type i_fault,
  output rpu_pkg::rpu_route_type i_route,
  output logic i_tcm_bank,
  input wire logic d_valid,
  input wire logic [31:0] d_addr,
  input wire logic d_priv,
  input wire logic d_write,
  input wire logic [1:0] d_size,
  input wire logic d_strict,
  output logic d_abort,
  output rpu_pkg::rpu_fault_type d_fault,
  output rpu_pkg::rpu_route_type d_route,
  output logic d_tcm_bank,
  input wire logic tcm_first_err,
  input wire logic tcm_second_err,
  output logic [3:0] master_inner_attr_out,
  output logic [3:0] master_outer_attr_out,
  output logic [3:0] periph_outer_attr_out
);
  import rpu_pkg::*;

  localparam int IDX_W = $clog2(REGION_COUNT);

  // ==========================================================
  // registers
  logic [31:0] system_control_reg;
  logic [IDX_W-1:0] region_sel_reg;
  logic [31:0] base_reg [REGION_COUNT];
  logic [15:0] size_reg [REGION_COUNT];
  logic [15:0] acc_reg [REGION_COUNT];
  logic [31:0] tcm_first_reg;
  logic [31:0] tcm_second_reg [2];
  logic [31:0] periph_reg;
  logic [4:0] status_reg;
  logic [4:0] status_next;
  logic [31:0] rdata_next;

  // ==========================================================
  // decode helpers
  function automatic logic [5:0] mem_decode(input logic [15:0] acc);
    logic [2:0] type_extension_field;
    logic [1:0] cb;
    logic [5:0] r;
    type_extension_field = acc[ACC_TEX_LO +: 3];
    cb = {acc[ACC_C_BIT], acc[ACC_B_BIT]};
    r = {MT_NORMAL, POL_NC, POL_NC};
    if (type_extension_field[2]) begin
      r = {MT_NORMAL, cb, type_extension_field[1:0]};
    end else if (type_extension_field == 3'b000) begin
      case (cb)
        2'b00: r = {MT_STRONG, POL_NC, POL_NC};
        2'b01: r = {MT_DEVICE, POL_NC, POL_NC};
        2'b10: r = {MT_NORMAL, POL_WT, POL_WT};
        default: r = {MT_NORMAL, POL_WBNA, POL_WBNA};
      endcase
    end else if (type_extension_field == 3'b001) begin
      if (cb == 2'b11) begin
        r = {MT_NORMAL, POL_WBWA, POL_WBWA};
      end
    end else if (type_extension_field == 3'b010) begin
      r = {MT_DEVICE, POL_NC, POL_NC};
    end
    if (r[3:2] == POL_WBNA) begin
      r[3:2] = POL_WBWA;
    end
    return r;
  endfunction

  // every cacheable code carries the read-allocate bit
  function automatic logic [3:0] cache_code(input logic [1:0] mt, input logic [1:0] pol);
    logic [3:0] c;
    c = CODE_NC;
    if (mt == MT_STRONG) begin
      c = CODE_STRONG;
    end else if (mt == MT_DEVICE) begin
      c = CODE_DEVICE;
    end else if (pol == POL_WT) begin
      c = CODE_WT;
    end else if (pol == POL_WBNA) begin
      c = CODE_WBNA;
    end else if (pol == POL_WBWA) begin
      c = CODE_WBWA;
    end
    return c;
  endfunction

  function automatic logic perm_ok(input logic [2:0] ap, input logic priv, input logic wr);
    logic ok;
    case (ap)
      3'h1: ok = priv;
      3'h2: ok = priv | ~wr;
      3'h3: ok = 1'b1;
      3'h5: ok = priv & ~wr;
      3'h6: ok = ~wr;
      default: ok = 1'b0;
    endcase
    return ok;
  endfunction

  function automatic logic window_hit(input logic [31:0] ctl, input logic [31:0] addr, input int size_log2);
    return ctl[WIN_EN_BIT] && (((addr ^ ctl) >> size_log2) == 32'h0);
  endfunction

  // later regions override earlier ones, so the highest match wins
  function automatic rpu_result_type evaluate(input logic [31:0] addr, input logic priv, input logic wr,
                                              input logic ex, input logic misal, input logic tcm_a,
                                              input logic [1:0] tcm_b, input logic per);
    rpu_result_type res;
    logic hit;
    logic [15:0] acc;
    logic [4:0] n;
    logic [32:0] span;
    logic [2:0] sub;
    logic [5:0] dec;
    logic shared;
    logic ex_ok;
    hit = 1'b0;
    acc = DEFAULT_ACC_MEM;
    for (int i = 0; i < REGION_COUNT; i++) begin
      n = size_reg[i][SZ_SIZE_LO +: 5];
      span = 33'h1 << ({1'b0, n} + 6'd1);
      sub = 3'(addr >> (n - 5'd2));
      if (REGION_PRESENT && size_reg[i][SZ_EN_BIT] &&
          (((addr ^ base_reg[i]) & ~(span[31:0] - 32'h1)) == 32'h0) &&
          !(n >= 5'd7 && size_reg[i][SZ_SUB_LO + sub])) begin
        hit = 1'b1;
        acc = acc_reg[i];
      end
    end
    if (!system_control_reg[SC_ENABLE_BIT] || (!hit && system_control_reg[SC_BG_BIT] && priv)) begin
      acc = (addr[31:30] == 2'b11) ? DEFAULT_ACC_DEV : DEFAULT_ACC_MEM;
    end
    dec = mem_decode(acc);
    shared = (dec[5:4] == MT_NORMAL) && acc[ACC_S_BIT];
    ex_ok = perm_ok(acc[ACC_AP_LO +: 3], priv, 1'b0) && !acc[ACC_XN_BIT] && dec[5:4] == MT_NORMAL && !per;
    res.fault = FAULT_NONE;
    if (misal) begin
      res.fault = FAULT_ALIGNMENT;
    end else if (system_control_reg[SC_ENABLE_BIT] && !hit && !(system_control_reg[SC_BG_BIT] && priv)) begin
      res.fault = FAULT_BACKGROUND;
    end else if (ex ? !ex_ok : !perm_ok(acc[ACC_AP_LO +: 3], priv, wr)) begin
      res.fault = FAULT_PERMISSION;
    end
    res.bank = 1'b0;
    res.inner = cache_code(dec[5:4], dec[3:2]);
    res.outer = per && dec[5:4] == MT_NORMAL ? CODE_NC : cache_code(dec[5:4], dec[1:0]);
    if (res.fault != FAULT_NONE) begin
      res.route = ROUTE_NONE;
    end else if (tcm_a) begin
      res.route = ROUTE_TCM_FIRST;
    end else if (|tcm_b) begin
      res.route = ROUTE_TCM_SECOND;
      res.bank = tcm_b[1];
    end else if (per) begin
      res.route = ROUTE_PERIPH;
    end else if (dec[5:4] == MT_NORMAL && dec[3:2] != POL_NC && !shared) begin
      res.route = ROUTE_CACHE;
    end else begin
      res.route = ROUTE_MASTER;
    end
    return res;
  endfunction

  // ==========================================================
  // access lookup, one per side, purely combinational
  logic [1:0] i_tcm_b_hit;
  logic [1:0] d_tcm_b_hit;
  logic d_misaligned;
  rpu_result_type i_res;
  rpu_result_type d_res;

  assign i_tcm_b_hit = {window_hit(tcm_second_reg[1], i_addr, TCM_SIZE_LOG2),
                        window_hit(tcm_second_reg[0], i_addr, TCM_SIZE_LOG2)};
  assign d_tcm_b_hit = {window_hit(tcm_second_reg[1], d_addr, TCM_SIZE_LOG2),
                        window_hit(tcm_second_reg[0], d_addr, TCM_SIZE_LOG2)};
  assign d_misaligned = (d_strict || system_control_reg[SC_ALIGN_BIT]) &&
                        ((d_addr[2:0] & 3'((4'h1 << d_size) - 4'h1)) != 3'h0);
  // a process, not an assign: evaluate reads the region table and control word, which an assign would not watch
  always_comb begin
    i_res = evaluate(i_addr, i_priv, 1'b0, 1'b1, 1'b0, window_hit(tcm_first_reg, i_addr, TCM_SIZE_LOG2),
                     i_tcm_b_hit, window_hit(periph_reg, i_addr, PERIPH_SIZE_LOG2));
    d_res = evaluate(d_addr, d_priv, d_write, 1'b0, d_misaligned,
                     window_hit(tcm_first_reg, d_addr, TCM_SIZE_LOG2),
                     d_tcm_b_hit, window_hit(periph_reg, d_addr, PERIPH_SIZE_LOG2));
  end

  // an idle side reports nothing, so it can never claim a port
  assign i_fault = i_valid ? i_res.fault : FAULT_NONE;
  assign d_fault = d_valid ? d_res.fault : FAULT_NONE;
  assign i_abort = i_fault != FAULT_NONE;
  assign d_abort = d_fault != FAULT_NONE;
  assign i_route = i_valid ? i_res.route : ROUTE_NONE;
  assign d_route = d_valid ? d_res.route : ROUTE_NONE;
  assign i_tcm_bank = i_valid && i_res.bank;
  assign d_tcm_bank = d_valid && d_res.bank;

  // data side takes the shared L2 attribute lines when both sides use one port
  assign master_inner_attr_out = d_route == ROUTE_MASTER ? d_res.inner :
                                 i_route == ROUTE_MASTER ? i_res.inner : CODE_STRONG;
  assign master_outer_attr_out = d_route == ROUTE_MASTER ? d_res.outer :
                                 i_route == ROUTE_MASTER ? i_res.outer : CODE_STRONG;
  assign periph_outer_attr_out = d_route == ROUTE_PERIPH ? d_res.outer :
                                 i_route == ROUTE_PERIPH ? i_res.outer : CODE_STRONG;

  // ==========================================================
  // register port
  logic wr_status;
  assign wr_status = reg_wr && reg_addr == OFF_STATUS;

  // sticky flags: an event in the clearing cycle survives the clear
  always_comb begin
    status_next = wr_status ? status_reg & ~reg_wdata[4:0] : status_reg;
    if (i_fault == FAULT_BACKGROUND || d_fault == FAULT_BACKGROUND) begin
      status_next[ST_BG_BIT] = 1'b1;
    end
    if (i_fault == FAULT_PERMISSION || d_fault == FAULT_PERMISSION) begin
      status_next[ST_PERM_BIT] = 1'b1;
    end
    if (d_fault == FAULT_ALIGNMENT) begin
      status_next[ST_ALIGN_BIT] = 1'b1;
    end
    if (tcm_first_err) begin
      status_next[ST_TCM_FIRST_ERR_BIT] = 1'b1;
    end
    if (tcm_second_err) begin
      status_next[ST_TCM_SECOND_ERR_BIT] = 1'b1;
    end
  end

  always_comb begin
    rdata_next = 32'h0;
    if (reg_addr == OFF_SYS_CTL) begin
      rdata_next = system_control_reg;
    end else if (reg_addr == OFF_REGION_SEL) begin
      rdata_next = 32'(region_sel_reg);
    end else if (reg_addr == OFF_REGION_BASE && REGION_PRESENT) begin
      rdata_next = base_reg[region_sel_reg];
    end else if (reg_addr == OFF_REGION_SIZE && REGION_PRESENT) begin
      rdata_next = {16'h0, size_reg[region_sel_reg]};
    end else if (reg_addr == OFF_REGION_ACC && REGION_PRESENT) begin
      rdata_next = {16'h0, acc_reg[region_sel_reg]};
    end else if (reg_addr == OFF_TCM_FIRST) begin
      rdata_next = tcm_first_reg;
    end else if (reg_addr == OFF_TCM_SECOND0) begin
      rdata_next = tcm_second_reg[0];
    end else if (reg_addr == OFF_TCM_SECOND1) begin
      rdata_next = tcm_second_reg[1];
    end else if (reg_addr == OFF_PERIPH) begin
      rdata_next = periph_reg;
    end else if (reg_addr == OFF_STATUS) begin
      rdata_next = {27'h0, status_reg};
    end
  end

  // only bits 0, 1 and 17 of the control word are implemented
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      system_control_reg <= SYS_CTL_RESET;
      region_sel_reg <= '0;
      tcm_first_reg <= 32'h0;
      tcm_second_reg[0] <= 32'h0;
      tcm_second_reg[1] <= 32'h0;
      periph_reg <= 32'h0;
      status_reg <= 5'h0;
      reg_rdata <= 32'h0;
    end else if (ce) begin
      status_reg <= status_next;
      reg_rdata <= reg_rd ? rdata_next : 32'h0;
      if (reg_wr && reg_addr == OFF_SYS_CTL) begin
        system_control_reg <= reg_wdata & 32'h0002_0003;
      end
      if (reg_wr && reg_addr == OFF_REGION_SEL) begin
        region_sel_reg <= reg_wdata[IDX_W-1:0];
      end
      if (reg_wr && reg_addr == OFF_TCM_FIRST) begin
        tcm_first_reg <= reg_wdata;
      end
      if (reg_wr && reg_addr == OFF_TCM_SECOND0) begin
        tcm_second_reg[0] <= reg_wdata;
      end
      if (reg_wr && reg_addr == OFF_TCM_SECOND1) begin
        tcm_second_reg[1] <= reg_wdata;
      end
      if (reg_wr && reg_addr == OFF_PERIPH) begin
        periph_reg <= reg_wdata;
      end
    end
  end

  // region table; writes are dropped when the unit is not built
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      for (int i = 0; i < REGION_COUNT; i++) begin
        base_reg[i] <= 32'h0;
        size_reg[i] <= 16'h0;
        acc_reg[i] <= 16'h0;
      end
    end else if (ce && reg_wr && REGION_PRESENT) begin
      if (reg_addr == OFF_REGION_BASE) begin
        base_reg[region_sel_reg] <= reg_wdata;
      end
      if (reg_addr == OFF_REGION_SIZE) begin
        size_reg[region_sel_reg] <= reg_wdata[15:0];
      end
      if (reg_addr == OFF_REGION_ACC) begin
        acc_reg[region_sel_reg] <= reg_wdata[15:0];
      end
    end
  end

  // ==========================================================
  // checks
  default clocking cb_main @(posedge clock); endclocking
  default disable iff (!rst_b);

  AST_ABORT_BLOCKS_PORTS: assert property ((d_abort |-> d_route == ROUTE_NONE) and (i_abort |-> i_route == ROUTE_NONE))
    else $error("aborted access was routed");
  AST_DISABLED_NO_BG: assert property (!system_control_reg[SC_ENABLE_BIT] |->
    (d_fault != FAULT_BACKGROUND && i_fault != FAULT_BACKGROUND))
    else $error("background fault while disabled");
  AST_STRICT_ALIGN: assert property (d_valid && system_control_reg[SC_ALIGN_BIT] && d_size == 2'h2 && d_addr[0]
    |-> d_fault == FAULT_ALIGNMENT)
    else $error("misaligned word not faulted");
  AST_STICKY_SET: assert property (ce && d_fault == FAULT_PERMISSION |=> status_reg[ST_PERM_BIT])
    else $error("permission fault not recorded");
  AST_PERIPH_NC: assert property (d_route == ROUTE_PERIPH |-> !periph_outer_attr_out[2])
    else $error("peripheral access marked cacheable");
  AST_INNER_NO_WBNA: assert property (master_inner_attr_out != CODE_WBNA)
    else $error("inner write-back no-allocate reached the bus");
  AST_NOT_PRESENT_ZERO: assert property (ce && reg_rd && !REGION_PRESENT && reg_addr == OFF_REGION_ACC
    |=> reg_rdata == 32'h0)
    else $error("absent region register read non-zero");
  AST_READ_ONE_CYCLE: assert property (ce && reg_rd && reg_addr == OFF_SYS_CTL ##1 ce && !reg_rd
    |-> reg_rdata == $past(system_control_reg) ##1 reg_rdata == 32'h0)
    else $error("control read data wrong or held");
  AST_TCM_FIRST: assert property (i_valid && !i_abort && window_hit(tcm_first_reg, i_addr, TCM_SIZE_LOG2)
    |-> i_route == ROUTE_TCM_FIRST)
    else $error("fetch in first tcm window not routed there");
  AST_INSTR_NO_EXEC_PERIPH: assert property (i_valid && window_hit(periph_reg, i_addr, PERIPH_SIZE_LOG2)
    |-> i_abort)
    else $error("fetch from peripheral window not aborted");

  COV_DATA_PERM: cover property (d_fault == FAULT_PERMISSION);
  COV_ICACHE: cover property (i_route == ROUTE_CACHE);
  COV_TCM_SECOND_HIGH: cover property (d_route == ROUTE_TCM_SECOND && d_tcm_bank);
  COV_PERIPH: cover property (d_route == ROUTE_PERIPH);
endmodule

// file: test/rpu_tcm_err_model.sv
// far-side model of the external logic that reports tcm errors
`timescale 1ns/1ps
module rpu_tcm_err_model (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic req_first,
  input wire logic req_second,
  output logic tcm_first_err,
  output logic tcm_second_err
);
  // ==========================================
  // error pulses
  // registered so the pulse leaves just after an edge, as real logic would
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      tcm_first_err <= 1'b0;
      tcm_second_err <= 1'b0;
    end else begin
      tcm_first_err <= req_first;
      tcm_second_err <= req_second;
    end
  end
endmodule

// file: test/rpu_core_tb.sv
// self-checking testbench of the region protection unit
`timescale 1ns/1ps
module rpu_core_tb;
  import rpu_pkg::*;
  logic clock, rst_b, ce, reg_wr, reg_rd, i_valid, i_priv, d_valid, d_priv, d_write, d_strict, req_a, req_b;
  logic [7:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata, i_addr, d_addr, rdata_bare;
  logic [1:0] d_size;
  logic i_abort, i_tcm_bank, d_abort, d_tcm_bank, tcm_first_err, tcm_second_err;
  rpu_fault_type i_fault, d_fault;
  rpu_route_type i_route, d_route;
  logic [3:0] m_in, m_out, p_out;
  logic [15:0] lfsr;
  int fail_count, samples_checked;
  rpu_core i_dut (.clock(clock), .rst_b(rst_b), .ce(ce), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .i_valid(i_valid), .i_addr(i_addr), .i_priv(i_priv),
    .i_abort(i_abort), .i_fault(i_fault), .i_route(i_route), .i_tcm_bank(i_tcm_bank), .d_valid(d_valid),
    .d_addr(d_addr), .d_priv(d_priv), .d_write(d_write), .d_size(d_size), .d_strict(d_strict), .d_abort(d_abort),
    .d_fault(d_fault), .d_route(d_route), .d_tcm_bank(d_tcm_bank), .tcm_first_err(tcm_first_err),
    .tcm_second_err(tcm_second_err), .master_inner_attr_out(m_in), .master_outer_attr_out(m_out),
    .periph_outer_attr_out(p_out));
  rpu_tcm_err_model i_err (.clock(clock), .rst_b(rst_b), .req_first(req_a), .req_second(req_b),
    .tcm_first_err(tcm_first_err), .tcm_second_err(tcm_second_err));
  // same stimulus into a build without the region table
  rpu_core #(.REGION_PRESENT(1'b0)) i_dut_bare (.clock(clock), .rst_b(rst_b), .ce(ce), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(rdata_bare), .i_valid(i_valid),
    .i_addr(i_addr), .i_priv(i_priv), .i_abort(), .i_fault(), .i_route(), .i_tcm_bank(), .d_valid(d_valid),
    .d_addr(d_addr), .d_priv(d_priv), .d_write(d_write), .d_size(d_size), .d_strict(d_strict), .d_abort(),
    .d_fault(), .d_route(), .d_tcm_bank(), .tcm_first_err(tcm_first_err), .tcm_second_err(tcm_second_err),
    .master_inner_attr_out(), .master_outer_attr_out(), .periph_outer_attr_out());
  // ==========================================
  // helpers
  function automatic logic [15:0] nxt(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction
  // default map: top quarter is device memory, which goes out on the master port
  function automatic rpu_route_type dflt(input logic [31:0] a);
    return (a[31:30] == 2'h3) ? ROUTE_MASTER : ROUTE_CACHE;
  endfunction
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic dchk(input rpu_fault_type f, input rpu_route_type r);
    chk(d_fault, f);
    chk(d_route, r);
    chk(d_abort, f != FAULT_NONE);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clock);
    reg_wr <= 1'b0;
    // callers look at the lookup next, so step past the edge that lands the write
    #1;
  endtask
  // read data stand only in the cycle after the strobe, so look just after that edge
  task automatic rd(input logic [7:0] a);
    @(posedge clock);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clock);
    reg_rd <= 1'b0;
    #1;
  endtask
  task automatic region(input logic [31:0] idx, input logic [31:0] b, input logic [31:0] s, input logic [31:0] c);
    wr(OFF_REGION_SEL, idx);
    wr(OFF_REGION_BASE, b);
    wr(OFF_REGION_SIZE, s);
    wr(OFF_REGION_ACC, c);
  endtask
  task automatic go(input logic [31:0] a, input logic p, input logic w, input logic [1:0] s, input logic st);
    @(posedge clock);
    i_addr <= a;
    d_addr <= a;
    i_priv <= p;
    d_priv <= p;
    d_write <= w;
    d_size <= s;
    d_strict <= st;
    #1;
  endtask
  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  // ==========================================
  // clock, watchdog and sequence
  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end
  initial begin
    #100000;
    fail_count++;
    tally_and_finish();
  end
  initial begin
    {rst_b, reg_wr, reg_rd, i_priv, d_priv, d_write, d_strict, req_a, req_b} = '0;
    {ce, i_valid, d_valid} = 3'h7;
    reg_addr = 8'h00;
    reg_wdata = 32'h0;
    i_addr = 32'h0;
    d_addr = 32'h0;
    d_size = 2'h0;
    lfsr = 16'h000C;
    repeat (12) @(posedge clock);
    rst_b <= 1'b1;
    rd(OFF_SYS_CTL);
    chk(reg_rdata, SYS_CTL_RESET);
    rd(8'h3C);
    chk(reg_rdata, 32'h0);
    for (int k = 0; k < 24; k++) begin
      lfsr = nxt(lfsr);
      go({lfsr[15:14], lfsr[13:0], lfsr}, lfsr[0], lfsr[1], lfsr[3:2], 1'b0);
      dchk(FAULT_NONE, dflt(d_addr));
      if (lfsr[15:14] != 2'h3) chk(i_route, ROUTE_CACHE);
      else chk(m_out, CODE_DEVICE);
    end
    $display("test default map done");
    wr(OFF_SYS_CTL, 32'h0000_0001);
    go(32'h0000_0100, 1'b1, 1'b0, 2'h2, 1'b0);
    dchk(FAULT_BACKGROUND, ROUTE_NONE);
    chk(m_out, 32'h0);
    wr(OFF_SYS_CTL, 32'h0002_0001);
    dchk(FAULT_NONE, ROUTE_CACHE);
    go(32'h0000_0100, 1'b0, 1'b0, 2'h2, 1'b0);
    dchk(FAULT_BACKGROUND, ROUTE_NONE);
    $display("test background done");
    region(0, 32'h0, 32'h3F, 32'h030B);
    region(1, 32'h1000, 32'h17, 32'h0603);
    region(2, 32'h8000, 32'h17, 32'h0335);
    go(32'h0000_1010, 1'b0, 1'b1, 2'h2, 1'b0);
    dchk(FAULT_PERMISSION, ROUTE_NONE);
    go(32'h0000_1010, 1'b0, 1'b0, 2'h2, 1'b0);
    dchk(FAULT_NONE, ROUTE_CACHE);
    go(32'h0000_8000, 1'b0, 1'b1, 2'h2, 1'b0);
    dchk(FAULT_NONE, ROUTE_MASTER);
    chk(m_in, CODE_WBWA);
    chk(m_out, CODE_WT);
    go(32'h0000_0200, 1'b0, 1'b1, 2'h2, 1'b0);
    dchk(FAULT_NONE, ROUTE_CACHE);
    chk(i_route, ROUTE_CACHE);
    rd(OFF_REGION_ACC);
    chk(reg_rdata, 32'h0000_0335);
    chk(rdata_bare, 32'h0);
    $display("test regions done");
    go(32'h0000_0202, 1'b1, 1'b0, 2'h2, 1'b1);
    dchk(FAULT_ALIGNMENT, ROUTE_NONE);
    go(32'h0000_0202, 1'b1, 1'b0, 2'h2, 1'b0);
    dchk(FAULT_NONE, ROUTE_CACHE);
    wr(OFF_SYS_CTL, 32'h0000_0003);
    dchk(FAULT_ALIGNMENT, ROUTE_NONE);
    go(32'h0000_0203, 1'b1, 1'b0, 2'h0, 1'b0);
    dchk(FAULT_NONE, ROUTE_CACHE);
    $display("test alignment done");
    wr(OFF_TCM_FIRST, 32'h0001_0001);
    wr(OFF_TCM_SECOND1, 32'h0002_0001);
    wr(OFF_PERIPH, 32'h0010_0001);
    go(32'h0001_0004, 1'b1, 1'b0, 2'h2, 1'b0);
    dchk(FAULT_NONE, ROUTE_TCM_FIRST);
    chk(i_route, ROUTE_TCM_FIRST);
    go(32'h0002_0008, 1'b1, 1'b0, 2'h2, 1'b0);
    dchk(FAULT_NONE, ROUTE_TCM_SECOND);
    chk({i_tcm_bank, d_tcm_bank}, 32'h3);
    go(32'h0010_0010, 1'b1, 1'b1, 2'h2, 1'b0);
    dchk(FAULT_NONE, ROUTE_PERIPH);
    chk(p_out, CODE_NC);
    chk(i_abort, 1'b1);
    chk(i_fault, FAULT_PERMISSION);
    // a write while the clock enable is low must be lost
    @(posedge clock);
    ce <= 1'b0;
    wr(OFF_PERIPH, 32'h0);
    go(32'h0010_0010, 1'b1, 1'b1, 2'h2, 1'b0);
    dchk(FAULT_NONE, ROUTE_PERIPH);
    @(posedge clock);
    ce <= 1'b1;
    $display("test routing done");
    @(posedge clock);
    i_valid <= 1'b0;
    d_valid <= 1'b0;
    wr(OFF_STATUS, 32'h0000_001F);
    req_a <= 1'b1;
    req_b <= 1'b1;
    @(posedge clock);
    req_a <= 1'b0;
    req_b <= 1'b0;
    repeat (2) @(posedge clock);
    rd(OFF_STATUS);
    chk(reg_rdata, 32'h0000_0018);
    $display("test tcm errors done");
    tally_and_finish();
  end
endmodule
